// ===== hw/host_port_pkg.sv
// Constants shared by the asynchronous host port design
package host_port_pkg;
  localparam int DATA_W = 28;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 4;
  localparam int RES_W = 23;
  localparam int MULT_W = 5;
  localparam logic [3:0] ADDR_CFG3 = 4'h3;
  localparam logic [3:0] ADDR_CFG4 = 4'h4;
  localparam logic [3:0] ADDR_FIFO1 = 4'h8;
  localparam logic [3:0] ADDR_FIFO2 = 4'h9;
  localparam logic [3:0] ADDR_BUSW = 4'he;
  localparam logic [3:0] ADDR_UNUSED = 4'hf;
  localparam int BIT_BUS16 = 4;
  localparam int BIT_TEST_SEL = 5;
  localparam int MULT_LSB = 0;
  localparam logic [27:0] CFG_RESET = 28'h0000000;
  localparam int COARSE_BITS = 23;
  localparam logic [15:0] HALF_ZERO = 16'h0000;
endpackage

// ===== hw/word_buffer.sv
// Two-entry valid/ready buffer for result words
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 28
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== hw/host_port.sv
// Asynchronous host port with 16-bit half-word assembly and test-input routing
// Operation
// - Test-select bit in register 3 routes three test inputs instead of measure inputs.
// - Register 14 bit 4 set selects 16-bit bus width, else full width.
// - In 16-bit mode the latched low half and the next high half combine into one 28-bit value.
// - In 16-bit mode each read or write strobe toggles the latch pointer.
// - Pointer toggling suppressed while chip select high, unless defect option set.
// - No register write occurs while chip select is high.
// - Writing zero to register 14 leaves 16-bit mode, pointer to low half.
// - Writes to address 15 change nothing except pointer movement.
// - Measurement range bounded by coarse counter of 2^23 M-Mode bins.
// - M-Mode bin equals R-Mode bin divided by multiplier setting.
// - Reads of address 8 return FIFO one, address 9 FIFO two.
`timescale 1ns/1ps
module host_port #(
  parameter bit ERRATUM_TOGGLE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Host bus pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] addr,
  input wire logic [27:0] data_in,
  output logic [27:0] data_out,
  output logic data_oe,
  // Measurement inputs
  input wire logic [2:0] measure_in,
  input wire logic [2:0] test_in,
  output logic [2:0] meas_hit,
  // Result streams from interface FIFOs
  input wire logic fifo1_valid,
  output logic fifo1_ready,
  input wire logic [22:0] fifo1_data,
  input wire logic fifo2_valid,
  output logic fifo2_ready,
  input wire logic [22:0] fifo2_data,
  // Status and configuration
  output logic bus16_mode,
  output logic test_select,
  output logic high_latch_sel,
  output logic [4:0] bin_multiplier,
  output logic [27:0] cfg4_word,
  output logic cfg4_write,
  output logic [22:0] range_limit
);
  // Positions of the three control pins in the synchroniser word
  localparam int CS_BIT = 2;
  localparam int RD_BIT = 1;
  localparam int WR_BIT = 0;
  // Idle level of the active-low control pins, so no false edge follows reset
  localparam logic [2:0] CTL_IDLE = 3'h7;
  // Number of hit channels behind the test multiplexer
  localparam int HITS = 3;
  // Zero padding above a low half-word on the 28-bit pins
  localparam logic [11:0] LOW_PAD = 12'h000;

  // Pin synchronisers (first stage read only by second); the third control
  // stage only serves edge detection on the strobes
  logic [2:0] ctl_s1_reg;
  logic [2:0] ctl_s2_reg;
  logic [2:0] ctl_s3_reg;
  logic [3:0] addr_s1_reg;
  logic [3:0] addr_s2_reg;
  logic [27:0] din_s1_reg;
  logic [27:0] din_s2_reg;

  // Control pins, reset to their idle level
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_s1_reg <= CTL_IDLE;
      ctl_s2_reg <= CTL_IDLE;
      ctl_s3_reg <= CTL_IDLE;
    end else begin
      ctl_s1_reg <= {chip_select_n, read_strobe_n, write_strobe_n};
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
    end
  end

  // Address and data pin synchronisers; the host holds both across the strobe
  always_ff @(posedge clk) begin
    addr_s1_reg <= addr;
    addr_s2_reg <= addr_s1_reg;
    din_s1_reg <= data_in;
    din_s2_reg <= din_s1_reg;
  end

  // Synchronised select and strobe edges
  logic cs_n;
  logic rd_end;
  logic wr_end;
  logic rd_start;
  logic strobe_end;
  // A strobe ends on its rising edge; a read starts on its falling edge
  assign cs_n = ctl_s2_reg[CS_BIT];
  assign rd_start = ctl_s3_reg[RD_BIT] && !ctl_s2_reg[RD_BIT];
  assign rd_end = !ctl_s3_reg[RD_BIT] && ctl_s2_reg[RD_BIT];
  assign wr_end = !ctl_s3_reg[WR_BIT] && ctl_s2_reg[WR_BIT];
  assign strobe_end = rd_end || wr_end;

  // Configuration registers
  logic [27:0] cfg3_reg;
  logic [27:0] busw_reg;
  logic [27:0] cfg4_reg;
  logic cfg4_wr_reg;
  logic ptr_reg;
  logic [15:0] low_latch_reg;
  logic wr_accept;
  logic [27:0] wr_word;

  // Writes land only while selected; in 16-bit mode only on the high half.
  // The low half waits in its latch, so a pair commits as one 28-bit word
  // and a lone low half never reaches a register. A write commits two to
  // three clocks after its strobe rises at the pin.
  assign wr_accept = wr_end && !cs_n && (!bus16_mode || ptr_reg);
  assign wr_word = bus16_mode ? {din_s2_reg[11:0], low_latch_reg} : din_s2_reg;

  // Register 3: test select and bin multiplier
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg3_reg <= host_port_pkg::CFG_RESET;
    end else if (wr_accept && addr_s2_reg == host_port_pkg::ADDR_CFG3) begin
      cfg3_reg <= wr_word;
    end
  end

  // Register 14: bus width
  always_ff @(posedge clk) begin
    if (srst) begin
      busw_reg <= host_port_pkg::CFG_RESET;
    end else if (wr_accept && addr_s2_reg == host_port_pkg::ADDR_BUSW) begin
      busw_reg <= wr_word;
    end
  end

  // Register 4: command word and its one-cycle write pulse; address 15 and
  // unmapped addresses match none of these decodes and change nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg4_reg <= host_port_pkg::CFG_RESET;
      cfg4_wr_reg <= 1'b0;
    end else begin
      cfg4_wr_reg <= wr_accept && (addr_s2_reg == host_port_pkg::ADDR_CFG4);
      if (wr_accept && addr_s2_reg == host_port_pkg::ADDR_CFG4) begin
        cfg4_reg <= wr_word;
      end
    end
  end

  // Configuration fields and the fixed range of the coarse counter
  assign bus16_mode = busw_reg[host_port_pkg::BIT_BUS16];
  assign test_select = cfg3_reg[host_port_pkg::BIT_TEST_SEL];
  assign bin_multiplier = cfg3_reg[host_port_pkg::MULT_LSB +: host_port_pkg::MULT_W];
  assign cfg4_word = cfg4_reg;
  assign cfg4_write = cfg4_wr_reg;
  assign range_limit = {host_port_pkg::COARSE_BITS{1'b1}};

  // Half-word latch pointer. Every strobe end moves it in 16-bit mode; the
  // defect option lets strobes meant for another chip move it too, which the
  // host undoes with the resync write sequence. After reset and whenever
  // 16-bit mode is off it rests on the low half.
  logic toggle_ok;
  assign toggle_ok = !cs_n || ERRATUM_TOGGLE;
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= 1'b0;
    end else if (!bus16_mode) begin
      ptr_reg <= 1'b0;
    end else if (strobe_end && toggle_ok) begin
      ptr_reg <= ~ptr_reg;
    end
  end
  assign high_latch_sel = ptr_reg;

  // Low half captured on the first write of a pair; the pointer still moves
  // if the host never sends the high half
  always_ff @(posedge clk) begin
    if (srst) begin
      low_latch_reg <= host_port_pkg::HALF_ZERO;
    end else if (wr_end && !cs_n && bus16_mode && !ptr_reg) begin
      low_latch_reg <= din_s2_reg[15:0];
    end
  end

  // Per-channel hit path: two synchroniser stages per pin, then the select
  // flip-flop, so a hit reaches meas_hit three clocks after the pin
  for (genvar ch = 0; ch < HITS; ch++) begin : g_hit
    logic meas_s1_reg;
    logic meas_s2_reg;
    logic test_s1_reg;
    logic test_s2_reg;
    logic hit_reg;

    // Synchronise both candidate pins
    always_ff @(posedge clk) begin
      meas_s1_reg <= measure_in[ch];
      meas_s2_reg <= meas_s1_reg;
      test_s1_reg <= test_in[ch];
      test_s2_reg <= test_s1_reg;
    end

    // Test inputs stand in for the measure inputs when selected
    always_ff @(posedge clk) begin
      if (srst) begin
        hit_reg <= 1'b0;
      end else begin
        hit_reg <= test_select ? test_s2_reg : meas_s2_reg;
      end
    end
    // Each channel drives its own bit of the output
    assign meas_hit[ch] = hit_reg;
  end

  // Result buffers per interface FIFO; two entries absorb a stalled host
  // without dropping a word, and the unused top bits of a result read as zero
  logic [27:0] b1_data;
  logic [27:0] b2_data;
  logic b1_valid;
  logic b2_valid;
  logic b1_ready;
  logic b2_ready;

  word_buffer #(
    .WIDTH(host_port_pkg::DATA_W)
  ) buf1 (
    .clk(clk),
    .srst(srst),
    .in_valid(fifo1_valid),
    .in_ready(fifo1_ready),
    .in_data({5'h00, fifo1_data}),
    .out_valid(b1_valid),
    .out_ready(b1_ready),
    .out_data(b1_data)
  );

  word_buffer #(
    .WIDTH(host_port_pkg::DATA_W)
  ) buf2 (
    .clk(clk),
    .srst(srst),
    .in_valid(fifo2_valid),
    .in_ready(fifo2_ready),
    .in_data({5'h00, fifo2_data}),
    .out_valid(b2_valid),
    .out_ready(b2_ready),
    .out_data(b2_data)
  );

  // Read word held for both halves of a 16-bit pair. Only the first (or only)
  // read of a word pops a buffer; an empty buffer answers zero and is not
  // popped, so a read ahead of data loses nothing.
  logic [27:0] rd_word_reg;
  logic rd_sel;
  logic rd_low_first;
  // Read select from the synchronised falling read strobe
  assign rd_sel = rd_start && !cs_n;
  assign rd_low_first = !bus16_mode || !ptr_reg;
  // Pop on the first (or only) read of a word
  assign b1_ready = rd_sel && rd_low_first && (addr_s2_reg == host_port_pkg::ADDR_FIFO1);
  assign b2_ready = rd_sel && rd_low_first && (addr_s2_reg == host_port_pkg::ADDR_FIFO2);

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_word_reg <= host_port_pkg::CFG_RESET;
    end else if (rd_sel && rd_low_first) begin
      case (addr_s2_reg)
        host_port_pkg::ADDR_FIFO1: rd_word_reg <= b1_valid ? b1_data : host_port_pkg::CFG_RESET;
        host_port_pkg::ADDR_FIFO2: rd_word_reg <= b2_valid ? b2_data : host_port_pkg::CFG_RESET;
        host_port_pkg::ADDR_CFG3: rd_word_reg <= cfg3_reg;
        host_port_pkg::ADDR_CFG4: rd_word_reg <= cfg4_reg;
        host_port_pkg::ADDR_BUSW: rd_word_reg <= busw_reg;
        default: rd_word_reg <= host_port_pkg::CFG_RESET;
      endcase
    end
  end

  // Half presented on the pins in 16-bit mode: the low half first, then bits
  // 27:16 right-aligned, so the host sees the same half order it writes in
  logic [27:0] out_word;
  always_comb begin
    out_word = rd_word_reg;
    if (bus16_mode && ptr_reg) begin
      out_word = {host_port_pkg::HALF_ZERO, rd_word_reg[host_port_pkg::DATA_W-1:host_port_pkg::HALF_W]};
    end else if (bus16_mode) begin
      out_word = {LOW_PAD, rd_word_reg[host_port_pkg::HALF_W-1:0]};
    end
  end

  // Output drive registers; the pins are driven while selected and reading
  always_ff @(posedge clk) begin
    if (srst) begin
      data_out <= host_port_pkg::CFG_RESET;
      data_oe <= 1'b0;
    end else begin
      data_oe <= !cs_n && !ctl_s2_reg[RD_BIT];
      data_out <= out_word;
    end
  end
endmodule

// ===== bench/host_port_props.sv
// Checker for the host port outputs
`timescale 1ns/1ps
module host_port_props #(
  parameter bit ERRATUM_TOGGLE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Watched pins
  input wire logic chip_select_n,
  input wire logic data_oe,
  input wire logic [2:0] measure_in,
  input wire logic [2:0] test_in,
  input wire logic [2:0] meas_hit,
  input wire logic bus16_mode,
  input wire logic test_select,
  input wire logic high_latch_sel,
  input wire logic cfg4_write,
  input wire logic [22:0] range_limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Reset state, range, pointer, write, output-enable and routing rules
  a_reset_state: assert property ($past(srst) |-> !bus16_mode && !high_latch_sel) else $error("not cleared");
  a_range_full: assert property (range_limit == 23'h7fffff) else $error("range wrong");
  a_ptr_low_off: assert property (!bus16_mode ##1 !bus16_mode |-> !high_latch_sel) else $error("ptr high");
  a_ptr_hold_cs: assert property ((!ERRATUM_TOGGLE && chip_select_n) [*6] |-> $stable(high_latch_sel)) else $error("ptr moved");
  a_no_write_cs: assert property (chip_select_n [*6] |-> !cfg4_write) else $error("write unselected");
  a_oe_needs_cs: assert property (chip_select_n [*4] |-> !data_oe) else $error("oe unselected");
  a_cfg4_pulse: assert property (cfg4_write |=> !cfg4_write) else $error("long pulse");
  a_test_route: assert property (test_select [*4] |-> meas_hit == $past(test_in, 3)) else $error("test route");
  a_meas_route: assert property (!test_select [*4] |-> meas_hit == $past(measure_in, 3)) else $error("meas route");
  // Main scenarios
  c_bus16: cover property ($rose(bus16_mode));
  c_cfg4: cover property (cfg4_write);
  c_ptr_high: cover property (high_latch_sel && bus16_mode);
endmodule
bind host_port host_port_props #(.ERRATUM_TOGGLE(ERRATUM_TOGGLE)) host_port_props_inst (.clk, .srst, .chip_select_n,
  .data_oe, .measure_in, .test_in, .meas_hit, .bus16_mode, .test_select, .high_latch_sel, .cfg4_write, .range_limit);

// ===== bench/host_bus_model.sv
// Host processor model on the asynchronous bus
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input wire logic clk,
  // Bus pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] addr,
  output logic [27:0] data_in,
  input wire logic [27:0] data_out
);
  // Idle bus
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 4'h0;
    data_in = 28'h0000000;
  end
  // Write cycle; cs_n high models a strobe meant for another chip
  task automatic wr(input logic cs_n, input logic [3:0] a, input logic [27:0] d);
    @(posedge clk);
    chip_select_n <= cs_n;
    addr <= a;
    data_in <= d;
    write_strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    data_in <= ~d; // Released bus shows no stale word
    repeat (4) @(posedge clk);
  endtask
  // Read cycle
  task automatic rd(input logic [3:0] a, output logic [27:0] d);
    @(posedge clk);
    chip_select_n <= 1'b0;
    addr <= a;
    read_strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    d = data_out;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // Pointer recovery, then 16-bit mode on
  task automatic resync;
    wr(1'b0, 4'hf, 28'h0000000);
    wr(1'b0, 4'he, 28'h0000000);
    wr(1'b0, 4'he, 28'h0000000);
    wr(1'b0, 4'he, 28'h0000010);
  endtask
endmodule

// ===== bench/tb_host_port.sv
// Self-checking bench for the host port
`timescale 1ns/1ps
module tb_host_port;
  logic clk, srst, chip_select_n, read_strobe_n, write_strobe_n, data_oe, cfg4_write;
  logic fifo1_valid, fifo1_ready, fifo2_valid, fifo2_ready, bus16_mode, test_select, high_latch_sel;
  logic [3:0] addr;
  logic [27:0] data_in, data_out, cfg4_word, rdat;
  logic [2:0] measure_in, test_in, meas_hit;
  logic [22:0] fifo1_data, fifo2_data, range_limit;
  logic [4:0] bin_multiplier;
  int mismatches, total_checks;
  host_port host_port_inst (.clk, .srst, .chip_select_n, .read_strobe_n, .write_strobe_n, .addr, .data_in,
    .data_out, .data_oe, .measure_in, .test_in, .meas_hit, .fifo1_valid, .fifo1_ready, .fifo1_data,
    .fifo2_valid, .fifo2_ready, .fifo2_data, .bus16_mode, .test_select, .high_latch_sel, .bin_multiplier,
    .cfg4_word, .cfg4_write, .range_limit);
  host_bus_model host_bus_model_inst (.clk, .chip_select_n, .read_strobe_n, .write_strobe_n, .addr, .data_in,
    .data_out);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Counts and verdict
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Offer one result word; valid held until ready is seen
  task automatic push(input bit sel, input logic [22:0] w);
    int n;
    n = 0;
    fifo1_valid <= !sel;
    fifo2_valid <= sel;
    fifo1_data <= w;
    fifo2_data <= w;
    do begin
      @(posedge clk);
      n++;
    end while ((sel ? fifo2_ready : fifo1_ready) !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      complete_run;
    end
  endtask
  // Half-word writes, then test-input routing and refused strobes
  task automatic t_bus16;
    host_bus_model_inst.resync;
    chk(bus16_mode, 1'b1);
    chk(high_latch_sel, 1'b0);
    host_bus_model_inst.wr(1'b0, 4'h3, 28'h0000025);
    chk(high_latch_sel, 1'b1);
    host_bus_model_inst.wr(1'b0, 4'h3, 28'h0000000);
    chk(high_latch_sel, 1'b0);
    chk({test_select, bin_multiplier}, 6'h25);
    host_bus_model_inst.wr(1'b0, 4'h4, 28'h0000300);
    host_bus_model_inst.wr(1'b0, 4'h4, 28'h0000700);
    chk(cfg4_word, 28'h7000300);
    measure_in <= 3'h2;
    test_in <= 3'h5;
    repeat (5) @(posedge clk);
    chk(meas_hit, 3'h5);
    host_bus_model_inst.wr(1'b1, 4'h3, 28'h0000000);
    host_bus_model_inst.wr(1'b1, 4'h3, 28'h0000000);
    chk({high_latch_sel, test_select}, 2'h1);
    host_bus_model_inst.wr(1'b0, 4'hf, 28'h0000000);
    host_bus_model_inst.wr(1'b0, 4'hf, 28'h0000000);
    chk({test_select, bin_multiplier}, 6'h25);
    host_bus_model_inst.wr(1'b0, 4'h3, 28'h0000000);
    host_bus_model_inst.wr(1'b0, 4'h3, 28'h0000000);
    repeat (5) @(posedge clk);
    chk(meas_hit, 3'h2);
    $display("done bus16");
  endtask
  // Full width, buffer fill and result reads
  task automatic t_fifo;
    host_bus_model_inst.wr(1'b0, 4'he, 28'h0000000); // Low half: 16-bit mode still on
    host_bus_model_inst.wr(1'b0, 4'he, 28'h0000000);
    chk({bus16_mode, high_latch_sel}, 2'h0);
    push(1'b0, 23'h123456);
    push(1'b0, 23'h654321);
    fifo1_valid <= 1'b0;
    @(posedge clk);
    chk(fifo1_ready, 1'b0);
    push(1'b1, 23'h0abcde);
    fifo2_valid <= 1'b0;
    host_bus_model_inst.rd(4'h8, rdat);
    chk(rdat[22:0], 23'h123456);
    host_bus_model_inst.rd(4'h8, rdat);
    chk(rdat[22:0], 23'h654321);
    host_bus_model_inst.rd(4'h9, rdat);
    chk(rdat[22:0], 23'h0abcde);
    // 16-bit read pair: low half, then bits 27:16 in the low 12 bits
    host_bus_model_inst.resync;
    push(1'b0, 23'h5a5a5a);
    fifo1_valid <= 1'b0;
    host_bus_model_inst.rd(4'h8, rdat);
    chk(rdat, 28'h0005a5a);
    host_bus_model_inst.rd(4'h8, rdat);
    chk(rdat, 28'h000005a);
    $display("done fifo");
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    measure_in = 3'h0;
    test_in = 3'h0;
    fifo1_valid = 1'b0;
    fifo2_valid = 1'b0;
    fifo1_data = 23'h000000;
    fifo2_data = 23'h000000;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({bus16_mode, high_latch_sel}, 2'h0);
    chk(range_limit, 23'h7fffff);
    $display("done reset");
    t_bus16;
    t_fifo;
    complete_run;
  end
endmodule
